// file: hdl/flash_erase_defines.svh
// constants of the erase sequencer and boot configuration
`ifndef FLASH_ERASE_DEFINES_SVH
`define FLASH_ERASE_DEFINES_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OP_WRITE_ENABLE      8'h06
`define OP_SECTOR_ERASE      8'h20
`define OP_SECTOR_ERASE_4B   8'h21
`define OP_SMALL_BLOCK       8'h52
`define OP_SMALL_BLOCK_4B    8'h5c
`define OP_LARGE_BLOCK       8'hd8
`define OP_LARGE_BLOCK_4B    8'hdc
`define OP_CHIP_ERASE        8'hc7
`define OP_CHIP_ERASE_ALT    8'h60

// ----------------------------------------------------------------------
// frame lengths in bits, opcode lengths in link clocks
// ----------------------------------------------------------------------
`define BITS_OPCODE          8'h08
`define BITS_ADDR3_FRAME     8'h20
`define BITS_ADDR4_FRAME     8'h28
`define LINK_QPI_OP_CLOCKS   6'h02
`define LINK_SPI_OP_CLOCKS   6'h08

// ----------------------------------------------------------------------
// erase unit shape, in 4K sectors
// ----------------------------------------------------------------------
`define SECTOR_SHIFT         12
`define LAST_SEC_SECTOR      4'h0
`define LAST_SEC_SMALL       4'h7
`define LAST_SEC_LARGE       4'hf

// ----------------------------------------------------------------------
// boot configuration register
// ----------------------------------------------------------------------
`define BOOT_CFG_RESET       32'hffff_ffff
`define BOOT_EN_N_BIT        0
`define BOOT_DELAY_LSB       1
`define BOOT_DELAY_MSB       2
`define BOOT_DELAY_CODE0     4'h7
`define BOOT_DELAY_CODE1     4'h9
`define BOOT_DELAY_CODE2     4'hb
`define BOOT_DELAY_CODE3     4'hd

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_SYS_MHZ          20
`define SECTOR_ERASE_TIME_US 30000
`define SMALL_ERASE_TIME_US  150000
`define LARGE_ERASE_TIME_US  250000
`define CHIP_ERASE_TIME_US   150000000

`endif

// file: hdl/flash_erase_pkg.sv
// types shared by the erase sequencer
package flash_erase_pkg;
  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_SCAN,
    ENG_RUN
  } eng_state_t;

  typedef enum logic [1:0] {
    ERASE_SECTOR,
    ERASE_SMALL_BLOCK,
    ERASE_LARGE_BLOCK,
    ERASE_CHIP
  } erase_kind_t;
endpackage : flash_erase_pkg

// file: hdl/serial_flash_erase_and_boot_cfg.sv
// serial flash erase command sequencer with boot configuration fields
//
// Notes on behaviour
// (R1) boot delay code selects 7/9/11/13, default 13
// (R2) host keeps boot clock within code's limit
// (R3) boot bit0 low enables boot, default one
// (R4) sector erase clears addressed 4K sector
// (R5) sector chosen by address bits above A12
// (R6) small block erase clears addressed 32K block
// (R7) small block chosen by bits above A15
// (R8) large block erase clears addressed 64K block
// (R9) chip erase is opcode only, whole array
// (R10) erase needs write enable latch set
// (R11) address erase needs cs rise after address
// (R12) chip erase needs cs rise on byte boundary
// (R13) three byte address, four when mode set
// (R14) opcode in 8 SPI or 2 QPI clocks
// (R15) SPI opcode samples only data line zero
// (R16) erase timer starts at chip select rise
// (R17) busy set during erase, clears with latch
// (R18) protected sector or block is not erased
// (R19) block protect mode: chip erase needs bp zero
// (R20) sector protect mode: chip skips protected blocks
// (R21) any protected sector skips its 64K block; small block and sector erase skip only their own 32K block or sector
// (R22) boot data width follows quad enable
`timescale 1ns/1ns
`include "flash_erase_defines.svh"

module serial_flash_erase_and_boot_cfg #(
  parameter int          ADDR_W     = 26,
  parameter logic [31:0] SECTOR_CYC =
    32'(`SECTOR_ERASE_TIME_US * `CLK_SYS_MHZ),
  parameter logic [31:0] SMALL_CYC  =
    32'(`SMALL_ERASE_TIME_US * `CLK_SYS_MHZ),
  parameter logic [31:0] LARGE_CYC  =
    32'(`LARGE_ERASE_TIME_US * `CLK_SYS_MHZ),
  parameter logic [31:0] CHIP_BLK_CYC =
    32'(64'(`CHIP_ERASE_TIME_US) * 64'(`CLK_SYS_MHZ)
        / 64'(2 ** (ADDR_W - 16)))
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       srst_i,
  input  wire logic                       sclk_i,
  input  wire logic                       cs_n_i,
  input  wire logic [3:0]                 sio_i,
  input  wire logic                       qpi_mode_i,
  input  wire logic                       four_byte_mode_i,
  input  wire logic                       extended_address_bit_i,
  input  wire logic                       protect_select_i,
  input  wire logic [3:0]                 block_protect_bits_i,
  input  wire logic                       quad_enable_i,
  input  wire logic                       persistent_sector_protect_i,
  input  wire logic                       dynamic_sector_protect_i,
  input  wire logic                       boot_cfg_we_i,
  input  wire logic [31:0]                boot_cfg_wdata_i,
  output logic [ADDR_W-13:0]              prot_query_o,
  output logic                            erase_req_o,
  output logic [ADDR_W-13:0]              erase_sector_o,
  output flash_erase_pkg::erase_kind_t    erase_kind_o,
  output logic                            write_in_progress_o,
  output logic                            write_enable_latch_o,
  output logic [31:0]                     boot_read_config_o,
  output logic                            boot_enable_o,
  output logic [3:0]                      boot_delay_cycles_o,
  output logic                            boot_quad_o
);
  import flash_erase_pkg::*;

  localparam int SW = ADDR_W - `SECTOR_SHIFT;

  // ----------------------------------------------------------------------
  // link side: runs on the host's serial clock
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  cnt;
    logic [31:0] sr1;
    logic [31:0] sr4;
    logic [7:0]  op1;
    logic [7:0]  op4;
  } link_state_t;

  link_state_t link_reg;
  link_state_t link_next;
  logic        fresh_reg;

  // the frame's own select ends it: sclk may stop right after the last bit
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  always_comb begin
    link_next = link_reg;
    if (!cs_n_i) begin
      if (fresh_reg) begin
        link_next.cnt = 6'h01;
        link_next.sr1 = {31'h0, sio_i[0]}; // R15
        link_next.sr4 = {28'h0, sio_i}; // R14
      end else begin
        if (link_reg.cnt != 6'h3f) begin
          link_next.cnt = link_reg.cnt + 6'h01;
        end
        link_next.sr1 = {link_reg.sr1[30:0], sio_i[0]}; // R15
        link_next.sr4 = {link_reg.sr4[27:0], sio_i};
      end
      if (link_next.cnt == `LINK_SPI_OP_CLOCKS) begin
        link_next.op1 = link_next.sr1[7:0]; // R14
      end
      if (link_next.cnt == `LINK_QPI_OP_CLOCKS) begin
        link_next.op4 = link_next.sr4[7:0]; // R14
      end
    end
  end

  always_ff @(posedge sclk_i) begin
    link_reg <= link_next;
  end

  // ----------------------------------------------------------------------
  // system side state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_s3;
    eng_state_t  state;
    erase_kind_t kind;
    logic        write_enable_latch;
    logic        write_in_progress;
    logic [SW-1:0] unit_base;
    logic [3:0]  unit_last;
    logic [3:0]  scan;
    logic [SW-1:0] query;
    logic [31:0] timer;
    logic        erase_req;
    logic [31:0] boot_cfg;
    logic        boot_quad;
  } sys_state_t;

  sys_state_t sys_reg;
  sys_state_t sys_next;

  // top-down protection: code n covers the top 2**(n-1) 64K blocks
  function automatic logic bp_covers(input logic [SW-1:0] sec,
                                     input logic [3:0]    bp);
    logic [SW-5:0] blk;
    logic [SW-4:0] span;
    blk  = sec[SW-1:4];
    span = (SW-3)'(1) << (bp - 4'h1);
    if (bp == 4'h0) begin
      bp_covers = 1'b0;
    end else if (bp == 4'hf) begin
      bp_covers = 1'b1;
    end else begin
      bp_covers = ({1'b0, blk} >= ((SW-3)'(1) << (SW-4)) - span);
    end
  endfunction : bp_covers

  function automatic logic [3:0] delay_of(input logic [1:0] code);
    case (code)
      2'h0:    delay_of = `BOOT_DELAY_CODE0;
      2'h1:    delay_of = `BOOT_DELAY_CODE1;
      2'h2:    delay_of = `BOOT_DELAY_CODE2;
      default: delay_of = `BOOT_DELAY_CODE3;
    endcase
  endfunction : delay_of

  // ----------------------------------------------------------------------
  // frame decode at chip select rise
  // ----------------------------------------------------------------------
  logic        frame_end;
  logic [7:0]  nbits;
  logic [7:0]  opcode;
  logic [31:0] araw;
  logic [31:0] addr32;
  logic [SW-1:0] sidx;
  logic        is_we;
  logic        is_se;
  logic        is_sb;
  logic        is_lb;
  logic        is_ce;
  logic        is_4b;
  logic        erase_cmd;
  logic        bits_ok;
  logic [SW-1:0] tgt_base;
  logic [3:0]  tgt_last;
  logic        ps0_refuse;
  logic        start_w;
  logic        unit_done;
  logic        sec_prot;

  always_comb begin
    // link words are quiet here: sclk has stopped before select rises
    frame_end = sys_reg.cs_s2 & ~sys_reg.cs_s3;
    nbits     = qpi_mode_i ? {link_reg.cnt, 2'b00} : {2'b00, link_reg.cnt};
    opcode    = qpi_mode_i ? link_reg.op4 : link_reg.op1;
    araw      = qpi_mode_i ? link_reg.sr4 : link_reg.sr1;
    is_we     = (opcode == `OP_WRITE_ENABLE);
    is_se     = (opcode == `OP_SECTOR_ERASE) ||
                (opcode == `OP_SECTOR_ERASE_4B);
    is_sb     = (opcode == `OP_SMALL_BLOCK) ||
                (opcode == `OP_SMALL_BLOCK_4B);
    is_lb     = (opcode == `OP_LARGE_BLOCK) ||
                (opcode == `OP_LARGE_BLOCK_4B);
    is_ce     = (opcode == `OP_CHIP_ERASE) ||
                (opcode == `OP_CHIP_ERASE_ALT);
    is_4b     = (opcode == `OP_SECTOR_ERASE_4B) ||
                (opcode == `OP_SMALL_BLOCK_4B) ||
                (opcode == `OP_LARGE_BLOCK_4B) || four_byte_mode_i;
    erase_cmd = is_se | is_sb | is_lb | is_ce;
    if (is_4b) begin
      addr32 = araw; // R13
    end else begin
      addr32 = {7'h0, extended_address_bit_i, araw[23:0]}; // R13
    end
    sidx = addr32[ADDR_W-1:`SECTOR_SHIFT]; // R5
    if (is_ce) begin
      bits_ok = (nbits == `BITS_OPCODE); // R9 R12
    end else if (is_4b) begin
      bits_ok = (nbits == `BITS_ADDR4_FRAME); // R11
    end else begin
      bits_ok = (nbits == `BITS_ADDR3_FRAME); // R11
    end
    if (is_lb || is_ce) begin
      tgt_base = {sidx[SW-1:4], 4'h0}; // R8
      tgt_last = `LAST_SEC_LARGE;
    end else if (is_sb) begin
      tgt_base = {sidx[SW-1:3], 3'h0}; // R7
      tgt_last = `LAST_SEC_SMALL; // R6
    end else begin
      tgt_base = sidx; // R4
      tgt_last = `LAST_SEC_SECTOR;
    end
    if (protect_select_i) begin
      ps0_refuse = 1'b0;
    end else if (is_ce) begin
      ps0_refuse = (block_protect_bits_i != 4'h0); // R19
    end else begin
      ps0_refuse = bp_covers(tgt_base | SW'(tgt_last),
                             block_protect_bits_i); // R18
    end
    start_w = frame_end && (sys_reg.state == ENG_IDLE) && sys_reg.write_enable_latch &&
              erase_cmd && bits_ok && !ps0_refuse; // R10 R16
    sec_prot = persistent_sector_protect_i | dynamic_sector_protect_i;
  end

  // ----------------------------------------------------------------------
  // erase engine
  // ----------------------------------------------------------------------
  always_comb begin
    sys_next           = sys_reg;
    unit_done          = 1'b0;
    sys_next.erase_req = 1'b0;
    sys_next.cs_s1     = cs_n_i;
    sys_next.cs_s2     = sys_reg.cs_s1;
    sys_next.cs_s3     = sys_reg.cs_s2;
    sys_next.boot_quad = quad_enable_i; // R22
    if (boot_cfg_we_i) begin
      sys_next.boot_cfg = boot_cfg_wdata_i;
    end
    case (sys_reg.state)
      ENG_IDLE: begin
        // select rise on a byte boundary after the opcode alone
        if (frame_end && is_we && nbits == `BITS_OPCODE) begin
          sys_next.write_enable_latch = 1'b1;
        end
        if (start_w) begin
          sys_next.write_in_progress       = 1'b1; // R16 R17
          sys_next.unit_base = is_ce ? '0 : tgt_base; // R9
          sys_next.unit_last = tgt_last;
          sys_next.scan      = 4'h0;
          sys_next.state     = ENG_SCAN;
          if (is_ce) begin
            sys_next.kind = ERASE_CHIP;
          end else if (is_lb) begin
            sys_next.kind = ERASE_LARGE_BLOCK;
          end else if (is_sb) begin
            sys_next.kind = ERASE_SMALL_BLOCK;
          end else begin
            sys_next.kind = ERASE_SECTOR;
          end
        end
      end
      ENG_SCAN: begin
        if (protect_select_i && sec_prot) begin
          unit_done = 1'b1; // R18 R20 R21
        end else if (!protect_select_i ||
                     sys_reg.scan == sys_reg.unit_last) begin
          sys_next.state     = ENG_RUN;
          sys_next.erase_req = 1'b1;
          case (sys_reg.kind)
            ERASE_SECTOR:      sys_next.timer = SECTOR_CYC - 32'h1;
            ERASE_SMALL_BLOCK: sys_next.timer = SMALL_CYC - 32'h1;
            ERASE_LARGE_BLOCK: sys_next.timer = LARGE_CYC - 32'h1;
            default:           sys_next.timer = CHIP_BLK_CYC - 32'h1;
          endcase
        end else begin
          sys_next.scan = sys_reg.scan + 4'h1;
        end
      end
      ENG_RUN: begin
        if (sys_reg.timer == 32'h0) begin
          unit_done = 1'b1;
        end else begin
          sys_next.timer = sys_reg.timer - 32'h1;
        end
      end
      default: begin
        sys_next.state = ENG_IDLE;
      end
    endcase
    if (unit_done) begin
      if (sys_reg.kind == ERASE_CHIP && sys_reg.unit_base[SW-1:4] != '1) begin
        sys_next.unit_base = sys_reg.unit_base + SW'(16); // R20
        sys_next.scan      = 4'h0;
        sys_next.state     = ENG_SCAN;
      end else begin
        sys_next.state = ENG_IDLE;
        sys_next.write_in_progress   = 1'b0; // R17
        sys_next.write_enable_latch   = 1'b0; // R17
      end
    end
    sys_next.query = sys_next.unit_base + SW'(sys_next.scan);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sys_reg           <= '0;
      sys_reg.cs_s1     <= 1'b1;
      sys_reg.cs_s2     <= 1'b1;
      sys_reg.cs_s3     <= 1'b1;
      sys_reg.state     <= ENG_IDLE;
      sys_reg.kind      <= ERASE_SECTOR;
      sys_reg.boot_cfg  <= `BOOT_CFG_RESET; // R1 R3
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prot_query_o         = sys_reg.query;
  assign erase_req_o          = sys_reg.erase_req;
  assign erase_sector_o       = sys_reg.unit_base;
  assign erase_kind_o         = sys_reg.kind;
  assign write_in_progress_o  = sys_reg.write_in_progress;
  assign write_enable_latch_o = sys_reg.write_enable_latch;
  assign boot_read_config_o   = sys_reg.boot_cfg;
  assign boot_enable_o        = ~sys_reg.boot_cfg[`BOOT_EN_N_BIT]; // R3
  assign boot_delay_cycles_o  = delay_of(
    sys_reg.boot_cfg[`BOOT_DELAY_MSB:`BOOT_DELAY_LSB]); // R1
  assign boot_quad_o          = sys_reg.boot_quad; // R22

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_boot_delay;
    @(posedge clk_sys_i) disable iff (srst_i)
      boot_delay_cycles_o == 4'h7 + {sys_reg.boot_cfg[2:1], 1'b0};
  endproperty
  a_boot_delay: assert property (p_boot_delay) // R1
    else $error("boot delay does not match its code");

  property p_boot_en;
    @(posedge clk_sys_i) disable iff (srst_i)
      boot_cfg_we_i |=> boot_enable_o == !$past(boot_cfg_wdata_i[0]);
  endproperty
  a_boot_en: assert property (p_boot_en) // R3
    else $error("boot enable not inverse of bit zero");

  property p_start_busy;
    @(posedge clk_sys_i) disable iff (srst_i)
      start_w |=> write_in_progress_o && sys_reg.state == ENG_SCAN;
  endproperty
  a_start_busy: assert property (p_start_busy) // R16
    else $error("busy not raised after accepted erase");

  property p_need_wel;
    @(posedge clk_sys_i) disable iff (srst_i)
      $rose(write_in_progress_o) |-> $past(write_enable_latch_o);
  endproperty
  a_need_wel: assert property (p_need_wel) // R10
    else $error("erase began without write enable latch");

  property p_done_clears;
    @(posedge clk_sys_i) disable iff (srst_i)
      $fell(write_in_progress_o) |-> !write_enable_latch_o &&
                                     sys_reg.state == ENG_IDLE;
  endproperty
  a_done_clears: assert property (p_done_clears) // R17
    else $error("latch still set after erase end");

  property p_bad_frame;
    @(posedge clk_sys_i) disable iff (srst_i)
      frame_end && erase_cmd && !bits_ok && !write_in_progress_o
        |=> !write_in_progress_o [*2];
  endproperty
  a_bad_frame: assert property (p_bad_frame) // R11
    else $error("misframed erase was started");

  property p_chip_bp;
    @(posedge clk_sys_i) disable iff (srst_i)
      erase_req_o && erase_kind_o == ERASE_CHIP && !protect_select_i
        |-> block_protect_bits_i == 4'h0;
  endproperty
  a_chip_bp: assert property (p_chip_bp) // R19
    else $error("chip erase ran with block protect set");

  property p_align;
    @(posedge clk_sys_i) disable iff (srst_i)
      erase_req_o && erase_kind_o != ERASE_SECTOR |->
        erase_sector_o[2:0] == 3'h0 &&
        (erase_kind_o == ERASE_SMALL_BLOCK || erase_sector_o[3:0] == 4'h0);
  endproperty
  a_align: assert property (p_align) // R7
    else $error("erase unit not aligned to its size");

  property p_skip_prot;
    @(posedge clk_sys_i) disable iff (srst_i)
      sys_reg.state == ENG_SCAN && protect_select_i && sec_prot
        |=> !erase_req_o;
  endproperty
  a_skip_prot: assert property (p_skip_prot) // R21
    else $error("protected unit was erased");

  property p_spi_line0;
    @(posedge sclk_i) disable iff (cs_n_i)
      !fresh_reg |=> link_reg.sr1[0] == $past(sio_i[0]);
  endproperty
  a_spi_line0: assert property (p_spi_line0) // R15
    else $error("line zero not shifted in");

  c_sector: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    start_w && is_se);
  c_chip: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    erase_req_o && erase_kind_o == ERASE_CHIP);
  c_skip: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    sys_reg.state == ENG_SCAN && protect_select_i && sec_prot);
  c_reject: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    frame_end && erase_cmd && sys_reg.write_enable_latch && !bits_ok);

endmodule : serial_flash_erase_and_boot_cfg

// file: dv/flash_host_model.sv
// host controller model that drives serial frames into the flash
`timescale 1ns/1ns
module flash_host_model (
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic [3:0] sio_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sio_o  = 4'h0;
  end
  // 64 ns link clock runs only inside a frame, well under any boot limit
  task automatic frame(input logic [39:0] d, input int n, input bit qpi,
                       input logic [2:0] junk);
    int i;
    #13;
    cs_n_o = 1'b0;
    for (i = n; i > 0; i = i - (qpi ? 4 : 1)) begin
      if (qpi) sio_o = d[i-1 -: 4];
      else sio_o = {junk ^ 3'(i), d[i-1]};
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #20 cs_n_o = 1'b1;
    // released lines must not keep showing the last value
    sio_o = ~sio_o;
  endtask : frame
endmodule : flash_host_model

// file: dv/testbench.sv
// self-checking bench for the erase sequencer and boot fields
`timescale 1ns/1ns
`include "flash_erase_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import flash_erase_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, sclk, cs_n, qpi = 1'b0, fourb = 1'b0;
  logic        ps = 1'b0, qe = 1'b0, p_en = 1'b0, d_en = 1'b0, we = 1'b0;
  logic [3:0]  sio, bp = 4'h0, dly;
  logic [5:0]  query, sec, lsec, psec = 6'h0;
  logic [31:0] wd = 32'h0, cfg, a;
  logic        req, write_in_progress, write_enable_latch, boot_en, bquad, pers, dyn;
  logic        extended_address_bit = 1'b0;
  erase_kind_t kind, lkind;
  int          seed = 32'h0495, bad_count = 0, checks = 0, reqs = 0, k;
  logic [7:0]  ops [6] = '{`OP_SECTOR_ERASE, `OP_SMALL_BLOCK,
    `OP_LARGE_BLOCK, `OP_SECTOR_ERASE_4B, `OP_SMALL_BLOCK_4B,
    `OP_LARGE_BLOCK_4B};

  always #25 clk = ~clk;
  assign pers = p_en && query == psec;
  assign dyn  = d_en && query == psec;
  always @(negedge clk) if (req) begin
    reqs++;
    lsec  = sec;
    lkind = kind;
  end

  flash_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sio_o(sio));
  serial_flash_erase_and_boot_cfg #(.ADDR_W(18), .SECTOR_CYC(32'h14),
    .SMALL_CYC(32'h1e), .LARGE_CYC(32'h28), .CHIP_BLK_CYC(32'h4)) i_dut (
    .clk_sys_i(clk), .srst_i(srst), .sclk_i(sclk), .cs_n_i(cs_n),
    .sio_i(sio), .qpi_mode_i(qpi), .four_byte_mode_i(fourb),
    .extended_address_bit_i(extended_address_bit), .protect_select_i(ps),
    .block_protect_bits_i(bp), .quad_enable_i(qe),
    .persistent_sector_protect_i(pers), .dynamic_sector_protect_i(dyn),
    .boot_cfg_we_i(we), .boot_cfg_wdata_i(wd), .prot_query_o(query),
    .erase_req_o(req), .erase_sector_o(sec), .erase_kind_o(kind),
    .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch),
    .boot_read_config_o(cfg), .boot_enable_o(boot_en),
    .boot_delay_cycles_o(dly), .boot_quad_o(bquad));

  // --------------------------------------------------------------------
  // tasks and expectations
  // --------------------------------------------------------------------
  function automatic logic [5:0] sec_of(logic [17:0] ad, erase_kind_t ek);
    if (ek == ERASE_SECTOR) return ad[17:12];
    if (ek == ERASE_SMALL_BLOCK) return {ad[17:15], 3'h0};
    return {ad[17:16], 4'h0};
  endfunction : sec_of

  task automatic write_enable_cmd();
    i_host.frame(40'(`OP_WRITE_ENABLE), 8, qpi, 3'($random(seed)));
    repeat (7) @(negedge clk);
    `CHK(write_enable_latch, 1'b1)
  endtask : write_enable_cmd

  // refused frames leave no request; wip must fall within a bound
  task automatic erase(input logic [39:0] d, input int n, input int nreq,
                       input logic [5:0] es, input erase_kind_t ek,
                       input logic ewel);
    int t;
    reqs = 0;
    i_host.frame(d, n, qpi, 3'($random(seed)));
    repeat (6) @(negedge clk);
    if (nreq > 0) `CHK(write_in_progress, 1'b1)
    for (t = 0; t < 3000 && write_in_progress !== 1'b0; t++) @(negedge clk);
    `CHK(write_in_progress, 1'b0)
    `CHK(reqs, nreq)
    if (nreq > 0) `CHK(lsec, es)
    if (nreq > 0) `CHK(lkind, ek)
    `CHK(write_enable_latch, ewel)
  endtask : erase

  task automatic test_done();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    #(30000 * 50);
    bad_count++;
    test_done();
  end

  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(cfg, 32'hffff_ffff)
    `CHK(dly, 4'hd)
    `CHK(boot_en, 1'b0)
    for (k = 0; k < 4; k++) begin
      wd = {$random(seed)} & 32'hffff_fff9 | 32'(k << 1);
      qe = 1'($random(seed));
      we = 1'b1;
      @(negedge clk);
      we = 1'b0;
      @(negedge clk);
      `CHK(cfg, wd)
      `CHK(dly, 4'(7 + 2 * k))
      `CHK(boot_en, ~wd[0])
      `CHK(bquad, qe)
    end
    $display("boot config test ended");
    erase({8'h0, `OP_SECTOR_ERASE, 24'h1000}, 32, 0, 6'h0, ERASE_SECTOR,
          1'b0);
    for (k = 0; k < 8; k++) begin
      a = {$random(seed)} & 32'h3ffff;
      qpi = 1'($random(seed));
      fourb = k > 5;
      extended_address_bit = 1'($random(seed));
      write_enable_cmd();
      if (k > 2 || fourb)
        erase({ops[k % 6], a}, 40, 1, sec_of(a[17:0], erase_kind_t'(k % 3)),
              erase_kind_t'(k % 3), 1'b0);
      else
        erase({8'h0, ops[k], a[23:0]}, 32, 1, sec_of(a[17:0],
              erase_kind_t'(k)), erase_kind_t'(k), 1'b0);
    end
    fourb = 1'b0;
    $display("erase kinds test ended");
    write_enable_cmd();
    erase({`OP_SECTOR_ERASE, a[23:0], 8'h0}, 40, 0, 6'h0, ERASE_SECTOR,
          1'b1);
    erase({28'h0, `OP_CHIP_ERASE, 4'h5}, 12, 0, 6'h0, ERASE_CHIP, 1'b1);
    bp = 4'h1;
    erase({8'h0, `OP_LARGE_BLOCK, 24'h3_4000}, 32, 0, 6'h0, ERASE_SECTOR,
          1'b1);
    erase(40'(`OP_CHIP_ERASE_ALT), 8, 0, 6'h0, ERASE_CHIP, 1'b1);
    bp = 4'h0;
    erase(40'(`OP_CHIP_ERASE), 8, 4, 6'h30, ERASE_CHIP, 1'b0);
    $display("refusal test ended");
    ps = 1'b1;
    p_en = 1'b1;
    psec = 6'h10 | 6'($random(seed) & 15);
    write_enable_cmd();
    erase({8'h0, `OP_SECTOR_ERASE, 6'h0, psec, 12'h5a5}, 32, 0, 6'h0,
          ERASE_SECTOR, 1'b0);
    write_enable_cmd();
    erase(40'(`OP_CHIP_ERASE), 8, 3, 6'h30, ERASE_CHIP, 1'b0);
    p_en = 1'b0;
    d_en = 1'b1;
    psec = 6'h3c;
    qpi = 1'b1;
    write_enable_cmd();
    erase(40'(`OP_CHIP_ERASE_ALT), 8, 3, 6'h20, ERASE_CHIP, 1'b0);
    $display("sector protect test ended");
    test_done();
  end
endmodule : testbench
